/* rtl/sme_exec.sv */
`timescale 1ns/10ps
module sme_exec
    import sme_pkg::*;
(
    input  wire logic              core_clk_i,   // Instruction clock
    input  wire logic              nrst_i,       // Sync reset, low
    input  wire logic              exec_i,       // Execute this cycle
    input  wire sme_instr_t        instr_i,      // Decoded instruction
    input  wire logic [DATA_W-1:0] frd_data_i,   // File read data
    input  wire logic [DATA_W-1:0] mrd_data_i,   // Indirect read data
    output logic      [FADR_W-1:0] frd_addr_o,   // File read address
    output logic      [ADDR_W-1:0] mrd_addr_o,   // Indirect address
    output logic                   mrd_en_o,     // Indirect read now
    output logic                   fwr_en_o,     // File write pulse
    output logic      [FADR_W-1:0] fwr_addr_o,   // File write address
    output logic      [DATA_W-1:0] fwr_data_o,   // File write data
    output logic      [DATA_W-1:0] acc_o,        // Accumulator
    output sme_flags_t             flags_o,      // Carry and zero
    output logic      [LIT7_W-1:0] latch_o,      // PC upper latch
    output logic      [ADDR_W-1:0] ptr0_o,       // Pointer 0
    output logic      [ADDR_W-1:0] ptr1_o        // Pointer 1
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [DATA_W-1:0] acc_q;
    logic [LIT7_W-1:0] latch_q;
    sme_flags_t        flags_q;
    logic [ADDR_W-1:0] ptr_q [2];
    logic              fwr_en_q;
    logic [FADR_W-1:0] fwr_addr_q;
    logic [DATA_W-1:0] fwr_data_q;

    logic [DATA_W-1:0] shf_res;
    logic              shf_c;
    logic [ADDR_W-1:0] ind_addr;
    logic [ADDR_W-1:0] ptr_nxt;
    logic [ADDR_W-1:0] ptr_sel;
    logic              do_lsr;
    logic              do_copy;
    logic              do_ind;
    logic              do_page;
    logic              do_lit;

    assign do_lsr  = exec_i && (instr_i.op == SME_OP_LSR);
    assign do_copy = exec_i && (instr_i.op == SME_OP_COPY);
    assign do_ind  = exec_i && (instr_i.op == SME_OP_IND);
    assign do_page = exec_i && (instr_i.op == SME_OP_PAGE);
    assign do_lit  = exec_i && (instr_i.op == SME_OP_LIT);

    // ------------------------------------------------------------
    // Datapath helpers
    // ------------------------------------------------------------
    sme_shifter u_shf (
        .opnd_i (frd_data_i),
        .res_o  (shf_res),
        .cout_o (shf_c)
    );

    assign ptr_sel = ptr_q[instr_i.psel];

    sme_addr_gen u_agen (
        .ptr_i  (ptr_sel),
        .mode_i (instr_i.imode),
        .ofs_i  (instr_i.ofs),
        .addr_o (ind_addr),
        .ptr_o  (ptr_nxt)
    );

    assign frd_addr_o = instr_i.faddr;
    assign mrd_addr_o = ind_addr;
    assign mrd_en_o   = do_ind;

    // ------------------------------------------------------------
    // Accumulator
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            acc_q <= ACC_RST;
        end else if (do_lsr && !instr_i.dest_f) begin
            acc_q <= shf_res;
        end else if (do_copy && !instr_i.dest_f) begin
            acc_q <= frd_data_i;
        end else if (do_ind) begin
            acc_q <= mrd_data_i;
        end else if (do_lit) begin
            acc_q <= instr_i.lit;
        end
    end

    // ------------------------------------------------------------
    // File write-back
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            fwr_en_q   <= 1'b0;
            fwr_addr_q <= '0;
            fwr_data_q <= '0;
        end else begin
            fwr_en_q   <= (do_lsr || do_copy) && instr_i.dest_f;
            fwr_addr_q <= instr_i.faddr;
            fwr_data_q <= do_lsr ? shf_res : frd_data_i;
        end
    end

    // ------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            flags_q <= '0;
        end else if (do_lsr) begin
            flags_q.c <= shf_c;
            flags_q.z <= (shf_res == '0);
        end else if (do_copy) begin
            flags_q.z <= (frd_data_i == '0);
        end else if (do_ind) begin
            flags_q.z <= (mrd_data_i == '0);
        end
    end

    // ------------------------------------------------------------
    // Page latch
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            latch_q <= LATCH_RST;
        end else if (do_page) begin
            latch_q <= instr_i.lit[LIT7_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Pointers
    // ------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_ptr
        always_ff @(posedge core_clk_i) begin
            if (!nrst_i) begin
                ptr_q[i] <= PTR_RST;
            end else if (do_ind && (instr_i.psel == 1'(i))) begin
                ptr_q[i] <= ptr_nxt;
            end
        end
    end

    assign acc_o      = acc_q;
    assign flags_o    = flags_q;
    assign latch_o    = latch_q;
    assign ptr0_o     = ptr_q[0];
    assign ptr1_o     = ptr_q[1];
    assign fwr_en_o   = fwr_en_q;
    assign fwr_addr_o = fwr_addr_q;
    assign fwr_data_o = fwr_data_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_lsr_acc;
        @(posedge core_clk_i) disable iff (!nrst_i)
        do_lsr && !instr_i.dest_f |=>
            acc_q == {1'b0, $past(frd_data_i[7:1])}
            && flags_q.c == $past(frd_data_i[0]);
    endproperty
    a_lsr_acc: assert property (p_lsr_acc)
        else $error("shift result or carry wrong");

    property p_lsr_file;
        @(posedge core_clk_i) disable iff (!nrst_i)
        do_lsr && instr_i.dest_f |=> fwr_en_q
            && fwr_data_q == {1'b0, $past(frd_data_i[7:1])}
            && $stable(acc_q);
    endproperty
    a_lsr_file: assert property (p_lsr_file)
        else $error("shift to file wrong");

    property p_copy;
        @(posedge core_clk_i) disable iff (!nrst_i)
        do_copy |=> (fwr_en_q == $past(instr_i.dest_f))
            && ($past(instr_i.dest_f) || acc_q == $past(frd_data_i));
    endproperty
    a_copy: assert property (p_copy)
        else $error("copy destination wrong");

    property p_copy_z;
        @(posedge core_clk_i) disable iff (!nrst_i)
        do_copy |=> flags_q.z == ($past(frd_data_i) == 8'h00);
    endproperty
    a_copy_z: assert property (p_copy_z)
        else $error("copy zero flag wrong");

    property p_ind;
        @(posedge core_clk_i) disable iff (!nrst_i)
        do_ind |=> acc_q == $past(mrd_data_i)
            && flags_q.z == ($past(mrd_data_i) == 8'h00);
    endproperty
    a_ind: assert property (p_ind)
        else $error("indirect load wrong");

    property p_rel;
        @(posedge core_clk_i) disable iff (!nrst_i)
        do_ind && instr_i.imode == SME_IM_REL |->
            mrd_addr_o == ptr_sel
                + {{10{instr_i.ofs[5]}}, instr_i.ofs}
            ##1 $stable(ptr0_o) && $stable(ptr1_o);
    endproperty
    a_rel: assert property (p_rel)
        else $error("relative address wrong");

    property p_preinc;
        @(posedge core_clk_i) disable iff (!nrst_i)
        do_ind && instr_i.imode == SME_IM_PREINC |->
            mrd_addr_o == ptr_sel + 16'h0001;
    endproperty
    a_preinc: assert property (p_preinc)
        else $error("pre-increment address wrong");

    property p_postdec;
        @(posedge core_clk_i) disable iff (!nrst_i)
        do_ind && instr_i.imode == SME_IM_POSTDEC && !instr_i.psel |->
            mrd_addr_o == ptr0_o
            ##1 ptr0_o == $past(ptr0_o) - 16'h0001;
    endproperty
    a_postdec: assert property (p_postdec)
        else $error("post-decrement wrong");

    property p_page;
        @(posedge core_clk_i) disable iff (!nrst_i)
        do_page |=> latch_q == $past(instr_i.lit[6:0])
            && $stable(flags_q);
    endproperty
    a_page: assert property (p_page)
        else $error("page latch load wrong");

    property p_lit;
        @(posedge core_clk_i) disable iff (!nrst_i)
        do_lit |=> acc_q == $past(instr_i.lit) && $stable(flags_q);
    endproperty
    a_lit: assert property (p_lit)
        else $error("literal load wrong");

    property p_lsr_z;
        @(posedge core_clk_i) disable iff (!nrst_i)
        do_lsr |=> flags_q.z == ($past(frd_data_i[7:1]) == 7'h00);
    endproperty
    a_lsr_z: assert property (p_lsr_z)
        else $error("shift zero flag wrong");

    property p_copy_file;
        @(posedge core_clk_i) disable iff (!nrst_i)
        do_copy && instr_i.dest_f |=> fwr_data_q == $past(frd_data_i)
            && fwr_addr_q == $past(instr_i.faddr) && $stable(acc_q);
    endproperty
    a_copy_file: assert property (p_copy_file)
        else $error("copy to file wrong");

    property p_predec;
        @(posedge core_clk_i) disable iff (!nrst_i)
        do_ind && instr_i.imode == SME_IM_PREDEC |->
            mrd_addr_o == ptr_sel - 16'h0001;
    endproperty
    a_predec: assert property (p_predec)
        else $error("pre-decrement address wrong");

    // Started at the top of the range this shows the wrap to zero
    property p_postinc;
        @(posedge core_clk_i) disable iff (!nrst_i)
        do_ind && instr_i.imode == SME_IM_POSTINC && !instr_i.psel |->
            mrd_addr_o == ptr0_o
            ##1 ptr0_o == $past(ptr0_o) + 16'h0001;
    endproperty
    a_postinc: assert property (p_postinc)
        else $error("post-increment wrong");

    property p_ptr_other;
        @(posedge core_clk_i) disable iff (!nrst_i)
        do_ind && !instr_i.psel |=> $stable(ptr1_o);
    endproperty
    a_ptr_other: assert property (p_ptr_other)
        else $error("unselected pointer moved");

    c_lsr_file: cover property (@(posedge core_clk_i)
        do_lsr && instr_i.dest_f);
    c_copy_zero: cover property (@(posedge core_clk_i)
        do_copy && instr_i.dest_f && frd_data_i == 8'h00);
    c_wrap: cover property (@(posedge core_clk_i)
        do_ind && instr_i.imode == SME_IM_POSTINC && ptr_sel == 16'hFFFF);
    c_ptr1: cover property (@(posedge core_clk_i)
        do_ind && instr_i.psel);

endmodule

/* rtl/sme_pkg.sv */
package sme_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    localparam int FADR_W = 7;
    localparam int LIT7_W = 7;
    localparam int OFS_W  = 6;

    // ------------------------------------------------------------
    // Reset values and pointer step
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] ACC_RST   = 8'h00;
    localparam logic [LIT7_W-1:0] LATCH_RST = 7'h00;
    localparam logic [ADDR_W-1:0] PTR_RST   = 16'h0000;
    localparam logic [ADDR_W-1:0] PTR_ONE   = 16'h0001;

    // ------------------------------------------------------------
    // Operations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SME_OP_NONE   = 3'b000,
        SME_OP_LSR    = 3'b001,
        SME_OP_COPY   = 3'b010,
        SME_OP_IND    = 3'b011,
        SME_OP_PAGE   = 3'b100,
        SME_OP_LIT    = 3'b101
    } sme_op_t;

    typedef enum logic [2:0] {
        SME_IM_PREINC  = 3'b000,
        SME_IM_PREDEC  = 3'b001,
        SME_IM_POSTINC = 3'b010,
        SME_IM_POSTDEC = 3'b011,
        SME_IM_REL     = 3'b100
    } sme_imode_t;

    typedef struct packed {
        sme_op_t             op;
        logic                dest_f;
        logic [FADR_W-1:0]   faddr;
        logic [DATA_W-1:0]   lit;
        sme_imode_t          imode;
        logic                psel;
        logic [OFS_W-1:0]    ofs;
    } sme_instr_t;

    typedef struct packed {
        logic                c;
        logic                z;
    } sme_flags_t;

endpackage

/* rtl/sme_shifter.sv */
`timescale 1ns/10ps
module sme_shifter
    import sme_pkg::*;
(
    input  wire logic [DATA_W-1:0] opnd_i,   // Operand byte
    output logic      [DATA_W-1:0] res_o,    // Shifted byte
    output logic                   cout_o    // Bit shifted out
);
    assign res_o  = {1'b0, opnd_i[DATA_W-1:1]};
    assign cout_o = opnd_i[0];
endmodule

/* rtl/sme_addr_gen.sv */
`timescale 1ns/10ps
module sme_addr_gen
    import sme_pkg::*;
(
    input  wire logic [ADDR_W-1:0] ptr_i,    // Current pointer value
    input  wire sme_imode_t        mode_i,   // Addressing form
    input  wire logic [OFS_W-1:0]  ofs_i,    // Signed offset
    output logic      [ADDR_W-1:0] addr_o,   // Effective address
    output logic      [ADDR_W-1:0] ptr_o     // Pointer after access
);
    logic [ADDR_W-1:0] ofs_ext;
    logic [ADDR_W-1:0] ptr_inc;
    logic [ADDR_W-1:0] ptr_dec;

    assign ofs_ext = {{(ADDR_W-OFS_W){ofs_i[OFS_W-1]}}, ofs_i};
    assign ptr_inc = ptr_i + PTR_ONE;
    assign ptr_dec = ptr_i - PTR_ONE;

    always_comb begin
        addr_o = ptr_i;
        ptr_o  = ptr_i;
        unique case (mode_i)
            SME_IM_PREINC: begin
                addr_o = ptr_inc;
                ptr_o  = ptr_inc;
            end
            SME_IM_PREDEC: begin
                addr_o = ptr_dec;
                ptr_o  = ptr_dec;
            end
            SME_IM_POSTINC: begin
                ptr_o  = ptr_inc;
            end
            SME_IM_POSTDEC: begin
                ptr_o  = ptr_dec;
            end
            SME_IM_REL: begin
                addr_o = ptr_i + ofs_ext;
            end
            default: begin
                addr_o = ptr_i;
                ptr_o  = ptr_i;
            end
        endcase
    end
endmodule

/* testbench/sme_shift_move_instr_exec_tb_top.sv */
`timescale 1ns/10ps
module sme_shift_move_instr_exec_tb_top
    import sme_pkg::*;
();
    logic              core_clk_i;
    logic              nrst_i;
    logic              exec_i;
    sme_instr_t        instr_i;
    logic [DATA_W-1:0] frd_data_i;
    logic [DATA_W-1:0] mrd_data_i;
    logic [FADR_W-1:0] frd_addr_o;
    logic [ADDR_W-1:0] mrd_addr_o;
    logic              mrd_en_o;
    logic              fwr_en_o;
    logic [FADR_W-1:0] fwr_addr_o;
    logic [DATA_W-1:0] fwr_data_o;
    logic [DATA_W-1:0] acc_o;
    sme_flags_t        flags_o;
    logic [LIT7_W-1:0] latch_o;
    logic [ADDR_W-1:0] ptr0_o;
    logic [ADDR_W-1:0] ptr1_o;
    int                miscompares;
    int                check_count;

    sme_exec DUT (
        .core_clk_i (core_clk_i), .nrst_i     (nrst_i),
        .exec_i     (exec_i),     .instr_i    (instr_i),
        .frd_data_i (frd_data_i), .mrd_data_i (mrd_data_i),
        .frd_addr_o (frd_addr_o), .mrd_addr_o (mrd_addr_o),
        .mrd_en_o   (mrd_en_o),   .fwr_en_o   (fwr_en_o),
        .fwr_addr_o (fwr_addr_o), .fwr_data_o (fwr_data_o),
        .acc_o      (acc_o),      .flags_o    (flags_o),
        .latch_o    (latch_o),    .ptr0_o     (ptr0_o),
        .ptr1_o     (ptr1_o)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk_v(input logic [ADDR_W-1:0] got,
                         input logic [ADDR_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_b(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic sme_instr_t mk(sme_op_t op, logic d,
        logic [FADR_W-1:0] fa, logic [DATA_W-1:0] lit, sme_imode_t im,
        logic ps, logic [OFS_W-1:0] ofs);
        mk = {op, d, fa, lit, im, ps, ofs};
    endfunction

    // Inputs land at the edge; checks wait 1 ns so updates settle first
    task automatic drive(input sme_instr_t ins,
                         input logic [DATA_W-1:0] fd,
                         input logic [DATA_W-1:0] md);
        @(posedge core_clk_i);
        exec_i     <= 1'b1;
        instr_i    <= ins;
        frd_data_i <= fd;
        mrd_data_i <= md;
        #1;
    endtask

    task automatic idle();
        @(posedge core_clk_i);
        exec_i <= 1'b0;
        #1;
    endtask

    task automatic chk_zero();
        chk_v(ADDR_W'(acc_o), 16'h0000);
        chk_v(ADDR_W'(latch_o), 16'h0000);
        chk_v(ptr0_o, 16'h0000);
        chk_v(ptr1_o, 16'h0000);
        chk_b(flags_o.c, 1'b0);
        chk_b(flags_o.z, 1'b0);
        chk_b(fwr_en_o, 1'b0);
    endtask

    task automatic conclude();
        if (miscompares == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Three shifts back to back, the middle one writing the file
    task automatic t_shift();
        drive(mk(SME_OP_LSR, 1'b0, 7'h05, 8'h00, SME_IM_REL, 1'b0,
                 6'h00), 8'h81, 8'h00);
        chk_v(ADDR_W'(frd_addr_o), 16'h0005);
        drive(mk(SME_OP_LSR, 1'b1, 7'h0A, 8'h00, SME_IM_REL, 1'b0,
                 6'h00), 8'hFE, 8'h00);
        chk_v(ADDR_W'(acc_o), 16'h0040);
        chk_b(flags_o.c, 1'b1);
        chk_b(flags_o.z, 1'b0);
        chk_b(fwr_en_o, 1'b0);
        drive(mk(SME_OP_LSR, 1'b0, 7'h05, 8'h00, SME_IM_REL, 1'b0,
                 6'h00), 8'h01, 8'h00);
        chk_b(fwr_en_o, 1'b1);
        chk_v(ADDR_W'(fwr_addr_o), 16'h000A);
        chk_v(ADDR_W'(fwr_data_o), 16'h007F);
        chk_b(flags_o.c, 1'b0);
        chk_v(ADDR_W'(acc_o), 16'h0040);
        idle();
        chk_v(ADDR_W'(acc_o), 16'h0000);
        chk_b(flags_o.c, 1'b1);
        chk_b(flags_o.z, 1'b1);
        chk_b(fwr_en_o, 1'b0);
    endtask

    task automatic t_copy();
        drive(mk(SME_OP_COPY, 1'b0, 7'h12, 8'h00, SME_IM_REL, 1'b0,
                 6'h00), 8'h3C, 8'h00);
        idle();
        chk_v(ADDR_W'(acc_o), 16'h003C);
        chk_b(flags_o.z, 1'b0);
        chk_b(fwr_en_o, 1'b0);
        drive(mk(SME_OP_COPY, 1'b1, 7'h11, 8'h00, SME_IM_REL, 1'b0,
                 6'h00), 8'h00, 8'h00);
        idle();
        chk_b(fwr_en_o, 1'b1);
        chk_v(ADDR_W'(fwr_addr_o), 16'h0011);
        chk_v(ADDR_W'(fwr_data_o), 16'h0000);
        chk_b(flags_o.z, 1'b1);
        chk_v(ADDR_W'(acc_o), 16'h003C);
        chk_b(flags_o.c, 1'b1);
    endtask

    // Zero flag is set here, so a nonzero literal shows it untouched
    task automatic t_literal();
        drive(mk(SME_OP_LIT, 1'b0, 7'h00, 8'h80, SME_IM_REL, 1'b0,
                 6'h00), 8'h00, 8'h00);
        drive(mk(SME_OP_PAGE, 1'b0, 7'h00, 8'hFF, SME_IM_REL, 1'b0,
                 6'h00), 8'h00, 8'h00);
        chk_v(ADDR_W'(acc_o), 16'h0080);
        chk_b(flags_o.z, 1'b1);
        chk_b(flags_o.c, 1'b1);
        idle();
        chk_v(ADDR_W'(latch_o), 16'h007F);
        chk_v(ADDR_W'(acc_o), 16'h0080);
        chk_b(flags_o.z, 1'b1);
        chk_b(flags_o.c, 1'b1);
    endtask

    // Walks the pointer across both wrap points and every form
    task automatic t_indirect();
        sme_imode_t        im[8] = '{SME_IM_PREDEC, SME_IM_POSTINC,
            SME_IM_PREINC, SME_IM_POSTDEC, SME_IM_REL, SME_IM_REL,
            SME_IM_REL, SME_IM_PREINC};
        logic              ps[8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
            1'b0, 1'b1};
        logic [OFS_W-1:0]  of[8] = '{6'h00, 6'h00, 6'h00, 6'h00,
            6'h20, 6'h1F, 6'h00, 6'h00};
        logic [ADDR_W-1:0] ad[8] = '{16'hFFFF, 16'hFFFF, 16'h0001,
            16'h0001, 16'hFFE0, 16'h001F, 16'h0000, 16'h0001};
        logic [ADDR_W-1:0] pa[8] = '{16'hFFFF, 16'h0000, 16'h0001,
            16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001};
        logic [DATA_W-1:0] md[8] = '{8'h00, 8'h5A, 8'hC3, 8'h00,
            8'h11, 8'h22, 8'h33, 8'h44};
        logic [ADDR_W-1:0] p0;
        logic [ADDR_W-1:0] p1;
        p0 = 16'h0000;
        p1 = 16'h0000;
        for (int k = 0; k < 8; k++) begin
            drive(mk(SME_OP_IND, 1'b0, 7'h00, 8'h00, im[k], ps[k], of[k]),
                  8'h00, md[k]);
            chk_v(mrd_addr_o, ad[k]);
            chk_b(mrd_en_o, 1'b1);
            if (ps[k]) begin
                p1 = pa[k];
            end else begin
                p0 = pa[k];
            end
            idle();
            chk_v(ADDR_W'(acc_o), ADDR_W'(md[k]));
            chk_v(ptr0_o, p0);
            chk_v(ptr1_o, p1);
            chk_b(flags_o.z, md[k] == 8'h00);
            chk_b(mrd_en_o, 1'b0);
        end
    endtask

    // A refused slot must leave state alone; then reset in mid-run
    task automatic t_refuse_reset();
        @(posedge core_clk_i);
        exec_i  <= 1'b0;
        instr_i <= mk(SME_OP_LIT, 1'b0, 7'h00, 8'h55, SME_IM_REL, 1'b0,
                      6'h00);
        idle();
        chk_v(ADDR_W'(acc_o), 16'h0044);
        @(posedge core_clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        #1;
        chk_zero();
        // First request in the cycle after release; an empty op first
        drive(mk(SME_OP_NONE, 1'b1, 7'h01, 8'h5A, SME_IM_REL, 1'b0,
                 6'h00), 8'hFF, 8'hFF);
        drive(mk(SME_OP_LIT, 1'b0, 7'h00, 8'h5A, SME_IM_REL, 1'b0,
                 6'h00), 8'h00, 8'h00);
        chk_v(ADDR_W'(acc_o), 16'h0000);
        chk_b(fwr_en_o, 1'b0);
        idle();
        chk_v(ADDR_W'(acc_o), 16'h005A);
        chk_b(flags_o.z, 1'b0);
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    // Whole run is under 100 cycles; 2000 leaves a wide margin
    initial begin
        repeat (2000) @(posedge core_clk_i);
        miscompares++;
        conclude();
    end

    initial begin
        miscompares = 0;
        check_count = 0;
        nrst_i     <= 1'b0;
        exec_i     <= 1'b0;
        instr_i    <= '0;
        frd_data_i <= 8'h00;
        mrd_data_i <= 8'h00;
        repeat (4) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        #1;
        chk_zero();
        t_shift();
        t_copy();
        t_literal();
        t_indirect();
        t_refuse_reset();
        conclude();
    end
endmodule
